// ===== rtl/spi_process_image.sv
// Added by the designer: the address map and register access over AHB-Lite.
`timescale 1ns/1ns
module spi_process_image
  import spi_pkg::*;
#(
  parameter int SLAVES = SPI_SLAVES
)(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [spi_pkg::SPI_SLAVES-1:0] coil_feedback,
  input wire logic [spi_pkg::SPI_SLAVES-1:0] breaker_state,
  input wire logic [spi_pkg::SPI_SLAVES-1:0] slave_fault_flag,
  input wire logic [4:0] slave_count,
  output logic [spi_pkg::SPI_SLAVES-1:0] coil_command,
  output logic irq
);
  import spi_pkg::*;

  // more slaves than the 8-byte image holds have no nibble to land in
  if (SLAVES < 1 || SLAVES > SPI_SLAVES) begin : g_bad_slaves
    $error("SLAVES must be 1..16");
  end

  ////////////////////////////////////////////////////////////////
  // field input synchronisers
  logic [SPI_SLAVES-1:0] coil_s1_reg;
  logic [SPI_SLAVES-1:0] coil_s2_reg;
  logic [SPI_SLAVES-1:0] brk_s1_reg;
  logic [SPI_SLAVES-1:0] brk_s2_reg;
  logic [SPI_SLAVES-1:0] flt_s1_reg;
  logic [SPI_SLAVES-1:0] flt_s2_reg;
  logic [4:0] cnt_s1_reg;
  logic [4:0] cnt_s2_reg;
  logic [4:0] cnt_s3_reg;
  logic [4:0] cnt_reg;

  // each field bit stands alone, so a plain two-flop chain per bit is enough
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      coil_s1_reg <= '0;
      coil_s2_reg <= '0;
    end else begin
      coil_s1_reg <= coil_feedback;
      coil_s2_reg <= coil_s1_reg;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      brk_s1_reg <= '0;
      brk_s2_reg <= '0;
    end else begin
      brk_s1_reg <= breaker_state;
      brk_s2_reg <= brk_s1_reg;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flt_s1_reg <= '0;
      flt_s2_reg <= '0;
    end else begin
      flt_s1_reg <= slave_fault_flag;
      flt_s2_reg <= flt_s1_reg;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_s1_reg <= 5'h00;
      cnt_s2_reg <= 5'h00;
      cnt_s3_reg <= 5'h00;
    end else begin
      cnt_s1_reg <= slave_count;
      cnt_s2_reg <= cnt_s1_reg;
      cnt_s3_reg <= cnt_s2_reg;
    end
  end

  // the count is a word whose bits may settle in different cycles,
  // so it is taken only once two synced samples agree
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= 5'h00;
    end else if (cnt_s2_reg == cnt_s3_reg) begin
      cnt_reg <= cnt_s3_reg;
    end
  end

  ////////////////////////////////////////////////////////////////
  // control and image registers
  logic [31:0] ctrl_reg;
  logic [SPI_IMG_BITS-1:0] out_img_reg;
  logic [SPI_IMG_BITS-1:0] in_img_reg;
  logic [SPI_SLAVES-1:0] cmd_reg;
  logic [SPI_ST_W-1:0] stat_reg, mask_reg;
  logic irq_reg;
  wire diag_copy_enable = ctrl_reg[0];

  // slave present when its position is within the physical count
  function automatic logic present_at(input int idx, input logic [4:0] cnt);
    present_at = (idx < SLAVES) && (5'(idx) < cnt);
  endfunction

  logic [SPI_IMG_BITS-1:0] in_img_next;
  logic [SPI_SLAVES-1:0] cmd_next;

  genvar g;
  generate
    for (g = 0; g < SPI_SLAVES; g = g + 1) begin : g_slave
      // position g+1 sits in byte g/2, low nibble for odd positions
      spi_nibble u_nib (
        .present(present_at(g, cnt_reg)),
        .coil(coil_s2_reg[g]),
        .breaker(brk_s2_reg[g]),
        .fault(flt_s2_reg[g]),
        .diag_copy_enable(diag_copy_enable),
        .nib(in_img_next[g*SPI_NIB +: SPI_NIB])
      );
      // only bit 0 of each output nibble is used, absent slaves get off
      assign cmd_next[g] = present_at(g, cnt_reg)
                           & out_img_reg[g*SPI_NIB + SPI_B_COIL];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // events
  wire ev_chg = (in_img_next != in_img_reg);
  logic [SPI_SLAVES-1:0] flt_vec;
  generate
    for (g = 0; g < SPI_SLAVES; g = g + 1) begin : g_flt
      assign flt_vec[g] = in_img_next[g*SPI_NIB + SPI_B_FAULT] &
                          ~in_img_reg[g*SPI_NIB + SPI_B_FAULT];
    end
  endgenerate
  wire ev_flt = |flt_vec;
  wire [SPI_ST_W-1:0] ev_vec = {ev_flt, ev_chg};

  ////////////////////////////////////////////////////////////////
  // ahb-lite slave
  logic dp_wr_reg;
  logic [7:0] dp_addr_reg;
  wire take = hsel & hready & htrans[1];
  wire [7:0] a_off = {haddr[7:2], 2'b00};
  wire wr_in = dp_wr_reg;

  // write strobe for one register offset in the data phase
  function automatic logic wr_hit(input logic wr, input logic [7:0] addr, input logic [7:0] off);
    wr_hit = wr && (addr == off);
  endfunction

  wire wr_out_lo = wr_hit(wr_in, dp_addr_reg, SPI_OFF_OUT_LO);
  wire wr_out_hi = wr_hit(wr_in, dp_addr_reg, SPI_OFF_OUT_HI);
  wire wr_ctrl = wr_hit(wr_in, dp_addr_reg, SPI_OFF_CTRL);
  wire wr_stat = wr_hit(wr_in, dp_addr_reg, SPI_OFF_STAT);
  wire wr_mask = wr_hit(wr_in, dp_addr_reg, SPI_OFF_MASK);
  wire [SPI_ST_W-1:0] w1c = wr_stat ? hwdata[SPI_ST_W-1:0] : '0;
  // set wins over a same-cycle clear
  wire [SPI_ST_W-1:0] stat_next = (stat_reg & ~w1c) | ev_vec;
  wire irq_next = |(stat_next & mask_reg);

  // read words, one named wire per register except ctrl_reg, which is read directly
  // the input image is read live so a read never returns a stale snapshot
  wire [31:0] rd_in_lo = in_img_next[31:0];
  wire [31:0] rd_in_hi = in_img_next[63:32];
  wire [31:0] rd_out_lo = out_img_reg[31:0];
  wire [31:0] rd_out_hi = out_img_reg[63:32];
  wire [31:0] rd_stat = {30'h0, stat_reg};
  wire [31:0] rd_mask = {30'h0, mask_reg};
  wire [31:0] rd_count = {27'h0, cnt_reg};

  logic [31:0] rd_mux;
  always_comb begin
    unique case (a_off)
      SPI_OFF_IN_LO: rd_mux = rd_in_lo;
      SPI_OFF_IN_HI: rd_mux = rd_in_hi;
      SPI_OFF_OUT_LO: rd_mux = rd_out_lo;
      SPI_OFF_OUT_HI: rd_mux = rd_out_hi;
      SPI_OFF_CTRL: rd_mux = ctrl_reg;
      SPI_OFF_STAT: rd_mux = rd_stat;
      SPI_OFF_MASK: rd_mux = rd_mask;
      SPI_OFF_COUNT: rd_mux = rd_count;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dp_wr_reg <= 1'b0;
      dp_addr_reg <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      dp_wr_reg <= take & hwrite;
      dp_addr_reg <= a_off;
      if (take && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // bus response: never stretched, never an error, yet still from flops
  logic hready_reg;
  logic hresp_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hready_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end else begin
      hready_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end
  end

  assign hreadyout = hready_reg;
  assign hresp = hresp_reg;

  ////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= SPI_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg <= {31'h0, hwdata[0]};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_img_reg[31:0] <= '0;
    end else if (wr_out_lo) begin
      out_img_reg[31:0] <= hwdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_img_reg[63:32] <= '0;
    end else if (wr_out_hi) begin
      out_img_reg[63:32] <= hwdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_reg <= '0;
    end else if (wr_mask) begin
      mask_reg <= hwdata[SPI_ST_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////
  // image tracking, commands and events
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      in_img_reg <= '0;
    end else begin
      in_img_reg <= in_img_next;
    end
  end

  // commands go out only from a flop, so the slave bus never sees a glitch
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_reg <= '0;
    end else begin
      cmd_reg <= cmd_next;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= stat_next;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign coil_command = cmd_reg;
  assign irq = irq_reg;
endmodule

// ===== rtl/spi_pkg.sv
package spi_pkg;
  localparam int SPI_SLAVES = 16;
  localparam int SPI_NIB = 4;
  localparam int SPI_IMG_BITS = 64;
  // nibble bit positions
  localparam int SPI_B_COIL = 0;
  localparam int SPI_B_BRK = 1;
  localparam int SPI_B_FAULT = 3;
  // register byte offsets
  localparam logic [7:0] SPI_OFF_IN_LO = 8'h00;
  localparam logic [7:0] SPI_OFF_IN_HI = 8'h04;
  localparam logic [7:0] SPI_OFF_OUT_LO = 8'h08;
  localparam logic [7:0] SPI_OFF_OUT_HI = 8'h0c;
  localparam logic [7:0] SPI_OFF_CTRL = 8'h10;
  localparam logic [7:0] SPI_OFF_STAT = 8'h14;
  localparam logic [7:0] SPI_OFF_MASK = 8'h18;
  localparam logic [7:0] SPI_OFF_COUNT = 8'h1c;
  // status bits
  localparam int SPI_ST_CHG = 0;
  localparam int SPI_ST_FLT = 1;
  localparam int SPI_ST_W = 2;
  localparam logic [31:0] SPI_CTRL_RST = 32'h0000_0000;
  localparam logic [1:0] SPI_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] SPI_HSIZE_WORD = 3'h2;
endpackage

// ===== rtl/spi_nibble.sv
`timescale 1ns/1ns
// builds one slave's input nibble from its synchronised field bits
module spi_nibble
  import spi_pkg::*;
(
  input wire logic present,
  input wire logic coil,
  input wire logic breaker,
  input wire logic fault,
  input wire logic diag_copy_enable,
  output logic [3:0] nib
);
  assign nib = present ? {diag_copy_enable & fault, 1'b0, breaker, coil} : 4'h0;
endmodule

// ===== dv/spi_pi_props.sv
`timescale 1ns/1ns
module spi_pi_props
  import spi_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [4:0] slave_count,
  input wire logic [SPI_SLAVES-1:0] coil_command,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire logic tk = hsel && hready && htrans[1];
  chk_ready_high: assert property (hreadyout) else $error("wait state");
  chk_resp_okay: assert property (!hresp) else $error("error response");
  chk_reset_cmd: assert property ($rose(reset_n) |-> coil_command == '0) else $error("cmd");
  chk_reset_irq: assert property ($rose(reset_n) |-> !irq) else $error("irq after reset");
  chk_reset_rdata: assert property ($rose(reset_n) |-> hrdata == '0) else $error("rdata");
  // sync delay of the count is covered by five quiet cycles
  chk_absent_off: assert property ($stable(slave_count)[*5] |->
    (coil_command >> slave_count) == '0) else $error("absent slave driven");
  chk_read_hold: assert property (!$past(tk && !hwrite) |-> $stable(hrdata))
    else $error("rdata moved");
  chk_irq_drop: assert property ($fell(irq) |-> $past(tk && hwrite, 2) || $past(tk && hwrite, 3))
    else $error("irq fell without write");
  cover property (tk && hwrite);
  cover property ($rose(irq));
  cover property (coil_command != '0);
endmodule
bind spi_process_image spi_pi_props spi_pi_props_inst (.clk, .reset_n, .hsel, .htrans,
  .hwrite, .hready, .hrdata, .hreadyout, .hresp, .slave_count, .coil_command, .irq);

// ===== dv/spi_slave_model.sv
`timescale 1ns/1ns
module spi_slave_model
  import spi_pkg::*;
(
  input wire logic clk,
  input wire logic [SPI_SLAVES-1:0] coil_command,
  output logic [SPI_SLAVES-1:0] coil_feedback
);
  // contactor pull-in takes time, so feedback trails the command
  logic [SPI_SLAVES-1:0] stage_reg [8];
  always @(posedge clk) begin
    stage_reg[0] <= coil_command;
    for (int i = 1; i < 8; i++) stage_reg[i] <= stage_reg[i-1];
  end
  assign coil_feedback = stage_reg[7];
endmodule

// ===== dv/slave_bus_process_image_bench.sv
`timescale 1ns/1ns
module slave_bus_process_image_bench;
  import spi_pkg::*;
  logic clk = 0, reset_n = 0, hsel = 0, hwrite = 0, hreadyout, hresp, irq;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = '0;
  logic [15:0] fb, brk = '0, flt = '0, cmd, ec;
  logic [4:0] n = '0;
  int mismatches = 0, check_count = 0, cyc = 0;
  always #5 clk = ~clk;
  spi_process_image spi_process_image_inst (.clk(clk), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .coil_feedback(fb), .breaker_state(brk), .slave_fault_flag(flt), .slave_count(n),
    .coil_command(cmd), .irq(irq));
  spi_slave_model spi_slave_model_inst (.clk(clk), .coil_command(cmd), .coil_feedback(fb));
  task finish_test;
    if (mismatches == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      finish_test;
    end
  end
  ////////////////////////////////////////
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= SPI_HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h0, a};
    hsize <= SPI_HSIZE_WORD;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask
  task run(input logic [4:0] k, input logic [63:0] o, input logic [15:0] b, f, input logic d);
    logic [63:0] e;
    n <= k;
    brk <= b;
    flt <= f;
    xfer(1'b1, SPI_OFF_CTRL, {31'h0, d});
    xfer(1'b1, SPI_OFF_OUT_LO, o[31:0]);
    xfer(1'b1, SPI_OFF_OUT_HI, o[63:32]);
    ec = '0;
    e = '0;
    // unused nibble bits of the output image are set on purpose
    for (int g = 0; g < 16; g++) if (g < k) ec[g] = o[4*g];
    for (int g = 0; g < 16; g++) if (g < k) e[4*g +: 4] = {f[g] & d, 1'b0, b[g], ec[g]};
    repeat (20) @(posedge clk);
    chk({16'h0, cmd}, {16'h0, ec});
    xfer(1'b0, SPI_OFF_IN_LO, 32'h0);
    chk(r, e[31:0]);
    xfer(1'b0, SPI_OFF_IN_HI, 32'h0);
    chk(r, e[63:32]);
    xfer(1'b0, SPI_OFF_OUT_HI, 32'h0);
    chk(r, o[63:32]);
    xfer(1'b0, SPI_OFF_COUNT, 32'h0);
    chk(r, {27'h0, k});
  endtask
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    run(5'd16, 64'he1f0_1e0f_f1e1_0ef1, 16'ha5c3, 16'hffff, 1'b0);
    run(5'd5, 64'hffff_ffff_ffff_ffff, 16'h3c5a, 16'h0013, 1'b1);
    run(5'd0, 64'h1111_1111_1111_1111, 16'hffff, 16'hffff, 1'b1);
    xfer(1'b1, SPI_OFF_MASK, 32'h1);
    repeat (4) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    xfer(1'b1, SPI_OFF_STAT, 32'h7);
    repeat (4) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b1, SPI_OFF_MASK, 32'h0);
    n <= 5'd16;
    brk <= 16'h0001;
    repeat (6) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b0, SPI_OFF_STAT, 32'h0);
    chk({31'h0, r[SPI_ST_CHG]}, 32'h1);
    chk({31'h0, r[SPI_ST_FLT]}, 32'h1);
    xfer(1'b0, 8'h20, 32'h0);
    chk(r, 32'h0);
    finish_test;
  end
endmodule
